// File: rsb_core.sv
// Purpose: Executes rotate-through-carry, bank select, subtract with borrow,
//   set carry, arithmetic shift right and window pointer loads.
// Assumes: Avalon-MM slave, 32-bit data, word address is the register index.
// Notes: Writing CONTROL starts one instruction; it runs its full cycle count.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rsb_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [7:0] flags_out,
  output logic [7:0] result_out,
  output logic busy_out
);
  import rsb_pkg::*;

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;
  // Release is retimed so that every flop below leaves reset on the same edge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] dst_r;
  logic [7:0] src_r;
  logic [7:0] opcode_r;
  logic [7:0] flags_r;
  logic [7:0] result_r;
  logic [7:0] wpa_r;
  logic [7:0] wpb_r;
  logic [2:0] cyc_r;
  logic [2:0] cyc_total_r;
  logic [1:0] bytes_r;
  logic illegal_r;
  logic done_r;
  logic ack_r;
  logic wait_r;
  logic [31:0] rdata_r;
  rsb_state_type state_r;

  logic wr_hit;
  logic rd_hit;
  logic bus_req;
  // Writes land on the edge at which the master sees waitrequest low, so a
  // write is only ever acted on once it has been answered; read data is captured one edge earlier.
  assign bus_req = avs_read || avs_write;
  assign wr_hit = avs_write && ack_r;
  assign rd_hit = avs_read && !ack_r;

  // ---------------------------------------------------------------
  // Decode of opcode into length and cycle count
  // ---------------------------------------------------------------
  logic [2:0] dec_cycles;
  logic [1:0] dec_bytes;
  logic dec_legal;
  always_comb begin
    dec_cycles = CYC_SHORT;
    dec_bytes = BYTES_TWO;
    dec_legal = 1'b1;
    unique case (avs_writedata[7:0])
      OPC_ROTC_DIR, OPC_ROTC_IND: begin
        dec_bytes = BYTES_TWO;
        dec_cycles = CYC_SHORT;
      end
      OPC_ASR_R, OPC_ASR_IND: begin
        dec_bytes = BYTES_TWO;
        dec_cycles = CYC_SHORT;
      end
      OPC_SELLO: begin
        dec_bytes = BYTES_ONE;
        dec_cycles = CYC_SHORT;
      end
      OPC_SELHI: begin
        dec_bytes = BYTES_ONE;
        dec_cycles = CYC_SHORT;
      end
      OPC_SETC: begin
        dec_bytes = BYTES_ONE;
        dec_cycles = CYC_SHORT;
      end
      OPC_LDWP: begin
        dec_bytes = BYTES_TWO;
        dec_cycles = CYC_SHORT;
      end
      OPC_SUBB_RR: begin
        dec_bytes = BYTES_TWO;
        dec_cycles = CYC_SHORT;
      end
      OPC_SUBB_RIR: begin
        dec_bytes = BYTES_TWO;
        dec_cycles = CYC_LONG;
      end
      OPC_SUBB_GG, OPC_SUBB_GIR, OPC_SUBB_LIT: begin
        dec_bytes = BYTES_THREE;
        dec_cycles = CYC_LONG;
      end
      default: begin
        // Unknown codes still run the short count so software always sees them end.
        dec_legal = 1'b0;
        dec_bytes = BYTES_ONE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Execute: combinational results
  // ---------------------------------------------------------------
  logic [7:0] res_nxt;
  logic [7:0] flags_nxt;
  logic [7:0] wpa_nxt;
  logic [7:0] wpb_nxt;
  logic res_wr;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic cin;
  always_comb begin
    cin = flags_r[FLG_C];
    diff = {1'b0, dst_r} - {1'b0, src_r} - {8'h00, cin};
    low_diff = {1'b0, dst_r[3:0]} - {1'b0, src_r[3:0]} - {4'h0, cin};
    res_nxt = dst_r;
    flags_nxt = flags_r;
    wpa_nxt = wpa_r;
    wpb_nxt = wpb_r;
    res_wr = 1'b0;
    unique case (opcode_r)
      OPC_ROTC_DIR, OPC_ROTC_IND: begin
        res_nxt = {cin, dst_r[7:1]};
        flags_nxt[FLG_C] = dst_r[0];
        flags_nxt[FLG_Z] = ({cin, dst_r[7:1]} == 8'h00);
        flags_nxt[FLG_S] = cin;
        flags_nxt[FLG_V] = cin ^ dst_r[7];
        res_wr = 1'b1;
      end
      OPC_ASR_R, OPC_ASR_IND: begin
        res_nxt = {dst_r[7], dst_r[7:1]};
        flags_nxt[FLG_C] = dst_r[0];
        flags_nxt[FLG_Z] = ({dst_r[7], dst_r[7:1]} == 8'h00);
        flags_nxt[FLG_S] = dst_r[7];
        flags_nxt[FLG_V] = 1'b0;
        res_wr = 1'b1;
      end
      OPC_SUBB_RR, OPC_SUBB_RIR, OPC_SUBB_GG, OPC_SUBB_GIR, OPC_SUBB_LIT: begin
        res_nxt = diff[7:0];
        flags_nxt[FLG_C] = diff[8];
        flags_nxt[FLG_Z] = (diff[7:0] == 8'h00);
        flags_nxt[FLG_S] = diff[7];
        flags_nxt[FLG_V] = (dst_r[7] != src_r[7]) && (diff[7] == src_r[7]);
        flags_nxt[FLG_D] = 1'b1;
        flags_nxt[FLG_H] = low_diff[4];
        res_wr = 1'b1;
      end
      OPC_SELLO: flags_nxt[FLG_BANK] = 1'b0;
      OPC_SELHI: flags_nxt[FLG_BANK] = 1'b1;
      OPC_SETC: flags_nxt[FLG_C] = 1'b1;
      OPC_LDWP: begin
        unique case (src_r[1:0])
          2'b10: wpa_nxt = {src_r[7:3], wpa_r[2:0]};
          2'b01: wpb_nxt = {src_r[7:3], wpb_r[2:0]};
          2'b00: begin
            wpa_nxt = {src_r[7:4], 1'b0, wpa_r[2:0]};
            wpb_nxt = {src_r[7:4], 1'b1, wpb_r[2:0]};
          end
          // Selector 11 names neither pointer, so both keep their value.
          2'b11: wpa_nxt = wpa_r;
        endcase
      end
      default: res_wr = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic start;
  assign start = wr_hit && (avs_address == IDX_CONTROL) && avs_byteenable[0] && (state_r == RSB_IDLE);
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= RSB_IDLE;
      cyc_r <= 3'h0;
      cyc_total_r <= 3'h0;
      bytes_r <= 2'h0;
      opcode_r <= RST_BYTE;
      illegal_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      unique case (state_r)
        RSB_IDLE: begin
          if (start) begin
            opcode_r <= avs_writedata[7:0];
            cyc_total_r <= dec_cycles;
            bytes_r <= dec_bytes;
            illegal_r <= !dec_legal;
            cyc_r <= 3'h1;
            done_r <= 1'b0;
            state_r <= RSB_BUSY;
          end
        end
        RSB_BUSY: begin
          cyc_r <= cyc_r + 3'h1;
          if (cyc_r == cyc_total_r - 3'h1) begin
            state_r <= RSB_DONE;
          end
        end
        RSB_DONE: begin
          done_r <= 1'b1;
          state_r <= RSB_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Architectural state: commit only in the final cycle
  // ---------------------------------------------------------------
  logic commit;
  assign commit = (state_r == RSB_DONE) && !illegal_r;
  logic sw_wr_op;
  assign sw_wr_op = wr_hit && (avs_address == IDX_OPERAND) && (state_r == RSB_IDLE);
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dst_r <= RST_BYTE;
      src_r <= RST_BYTE;
    end else if (sw_wr_op) begin
      if (avs_byteenable[0]) begin
        dst_r <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        src_r <= avs_writedata[15:8];
      end
    end
  end

  // A commit and a software write never meet: writes are refused outside idle.
  // single commit point
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      flags_r <= RST_BYTE;
      result_r <= RST_BYTE;
      wpa_r <= RST_BYTE;
      wpb_r <= RST_BYTE;
    end else if (commit) begin
      flags_r <= flags_nxt;
      wpa_r <= wpa_nxt;
      wpb_r <= wpb_nxt;
      if (res_wr) begin
        result_r <= res_nxt;
      end
    end else if (wr_hit && (state_r == RSB_IDLE) && avs_byteenable[0]) begin
      if (avs_address == IDX_WINDOW_POINTER_A) begin
        wpa_r <= avs_writedata[7:0];
      end
      if (avs_address == IDX_WINDOW_POINTER_B) begin
        wpb_r <= avs_writedata[7:0];
      end
      if (avs_address == IDX_FLAGS) begin
        flags_r <= avs_writedata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Avalon slave: one wait cycle, answer on the second edge
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (avs_address)
      IDX_OPERAND: rd_mux = {16'h0000, src_r, dst_r};
      IDX_CONTROL: rd_mux = {24'h000000, opcode_r};
      IDX_RESULT: rd_mux = {24'h000000, result_r};
      IDX_STATUS: rd_mux = {24'h000000, 1'b0, state_r != RSB_IDLE, illegal_r, done_r, 1'b0, cyc_total_r};
      IDX_INFO: rd_mux = {30'h0, bytes_r};
      IDX_FLAGS: rd_mux = {24'h000000, flags_r};
      IDX_WINDOW_POINTER_A: rd_mux = {24'h000000, wpa_r};
      IDX_WINDOW_POINTER_B: rd_mux = {24'h000000, wpb_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req && !ack_r;
      wait_r <= !(bus_req && !ack_r);
      if (rd_hit) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  logic busy_r;
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= start || ((state_r != RSB_IDLE) && (state_r != RSB_DONE));
    end
  end
  assign flags_out = flags_r;
  assign result_out = result_r;
  assign busy_out = busy_r;
endmodule
`default_nettype wire

// File: rsb_core_checker.sv
// Purpose: Checks the committed results of each instruction except the window pointer load at the core ports.
// Assumes: One instruction at a time, operands written before CONTROL.
// Notes: Commit lands on the edge at which busy falls; one cycle of slack is still allowed.
`timescale 1ns/1ns
`default_nettype none
module rsb_core_checker import rsb_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] flags_out,
  input wire logic [7:0] result_out,
  input wire logic busy_out
);
  // ------
  // Operand capture
  // ------
  logic [7:0] op_r, dst_r, src_r, fin_r;
  logic wr_done, is_rot, is_sub, asr;
  assign wr_done = avs_write && !avs_waitrequest;
  assign is_rot = op_r == OPC_ROTC_DIR || op_r == OPC_ROTC_IND;
  assign is_sub = op_r >= OPC_SUBB_RR && op_r <= OPC_SUBB_LIT;
  assign asr = op_r == OPC_ASR_R || op_r == OPC_ASR_IND;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dst_r <= 8'h00;
      src_r <= 8'h00;
    end else if (wr_done && avs_address == IDX_OPERAND && !busy_out) begin
      dst_r <= avs_writedata[7:0];
      src_r <= avs_writedata[15:8];
    end
  end
  // The flags seen when the opcode lands are the inputs of that instruction.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      op_r <= 8'h00;
      fin_r <= 8'h00;
    end else if (wr_done && avs_address == IDX_CONTROL && !busy_out) begin
      op_r <= avs_writedata[7:0];
      fin_r <= flags_out;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_rrc_res;
    $fell(busy_out) && is_rot |-> ##[0:1] result_out == {fin_r[7], dst_r[7:1]};
  endproperty
  a_rrc_res: assert property (p_rrc_res) else $error("rotate result wrong");
  property p_rrc_flg;
    $fell(busy_out) && is_rot |-> ##[0:1] flags_out[7:2] ==
      {dst_r[0], {fin_r[7], dst_r[7:1]} == 8'h00, fin_r[7], dst_r[7] ^ fin_r[7], fin_r[3:2]};
  endproperty
  a_rrc_flg: assert property (p_rrc_flg) else $error("rotate flags wrong");
  property p_bank;
    $fell(busy_out) && (op_r == OPC_SELLO || op_r == OPC_SELHI) |->
      ##[0:1] flags_out == {fin_r[7:1], op_r == OPC_SELHI};
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
  property p_sbc_res;
    $fell(busy_out) && is_sub |-> ##[0:1] result_out == dst_r - src_r - fin_r[7] &&
      flags_out[7] == ({1'b0, src_r} + fin_r[7] > {1'b0, dst_r});
  endproperty
  a_sbc_res: assert property (p_sbc_res) else $error("subtract result wrong");
  property p_sbc_vdh;
    $fell(busy_out) && is_sub |-> ##[0:1] flags_out[3] && flags_out[4] == (dst_r[7] != src_r[7] &&
      result_out[7] == src_r[7]) && flags_out[2] == ({1'b0, src_r[3:0]} + fin_r[7] > {1'b0, dst_r[3:0]});
  endproperty
  a_sbc_vdh: assert property (p_sbc_vdh) else $error("subtract flags wrong");
  property p_setc;
    $fell(busy_out) && op_r == OPC_SETC |-> ##[0:1] flags_out == {1'b1, fin_r[6:0]};
  endproperty
  a_setc: assert property (p_setc) else $error("set carry wrong");
  property p_asr_res;
    $fell(busy_out) && asr |-> ##[0:1] result_out == {dst_r[7], dst_r[7:1]} && flags_out[7] == dst_r[0];
  endproperty
  a_asr_res: assert property (p_asr_res) else $error("shift result wrong");
  property p_asr_flg;
    $fell(busy_out) && asr |-> ##[0:1] flags_out[6:2] == {dst_r[7:1] == 7'h00, dst_r[7], 1'b0, fin_r[3:2]};
  endproperty
  a_asr_flg: assert property (p_asr_flg) else $error("shift flags wrong");
endmodule
bind rsb_core rsb_core_checker rsb_core_checker_i (.core_clk(core_clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .flags_out(flags_out), .result_out(result_out), .busy_out(busy_out));
`default_nettype wire

// File: rsb_pkg.sv
// Purpose: Shared constants for the rotate, subtract, bank and pointer datapath.
// Assumes: 8-bit data, flags byte laid out C,Z,S,V,D,H,-,BANK from bit 7 down.
// Notes: Register offsets are word indices; byte address is four times the index.
package rsb_pkg;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_ROTC_DIR = 8'hc0;
  localparam logic [7:0] OPC_ROTC_IND = 8'hc1;
  localparam logic [7:0] OPC_SELLO = 8'h4f;
  localparam logic [7:0] OPC_SELHI = 8'h5f;
  localparam logic [7:0] OPC_SUBB_RR = 8'h32;
  localparam logic [7:0] OPC_SUBB_RIR = 8'h33;
  localparam logic [7:0] OPC_SUBB_GG = 8'h34;
  localparam logic [7:0] OPC_SUBB_GIR = 8'h35;
  localparam logic [7:0] OPC_SUBB_LIT = 8'h36;
  localparam logic [7:0] OPC_SETC = 8'hdf;
  localparam logic [7:0] OPC_ASR_R = 8'hd0;
  localparam logic [7:0] OPC_ASR_IND = 8'hd1;
  localparam logic [7:0] OPC_LDWP = 8'h31;
  // ---------------------------------------------------------------
  // Flag bit positions
  // ---------------------------------------------------------------
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  localparam int FLG_BANK = 0;
  // ---------------------------------------------------------------
  // Register map (word indices)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_WINDOW_POINTER_A = 8'hd6;
  localparam logic [7:0] IDX_WINDOW_POINTER_B = 8'hd7;
  localparam logic [7:0] IDX_FLAGS = 8'hd5;
  localparam logic [7:0] IDX_OPERAND = 8'hd0;
  localparam logic [7:0] IDX_CONTROL = 8'hd1;
  localparam logic [7:0] IDX_RESULT = 8'hd2;
  localparam logic [7:0] IDX_STATUS = 8'hd3;
  localparam logic [7:0] IDX_INFO = 8'hd4;
  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;
  localparam logic [1:0] BYTES_THREE = 2'h3;
  typedef enum logic [1:0] {
    RSB_IDLE,
    RSB_BUSY,
    RSB_DONE
  } rsb_state_type;
endpackage

// File: testbench.sv
// Purpose: Self-checking bench that runs every opcode through the register bus.
// Assumes: The bus master waits on waitrequest; one instruction at a time.
// Notes: Row expectations are worked out by hand from the flag equations.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import rsb_pkg::*;
  typedef struct {
    logic [7:0] op, dst, src, fin, res, fout, pb;
    logic [2:0] cyc;
    logic [1:0] byt, kind;
  } rsb_row_type;
  // ------
  // Instruction table: kind 0 reads the result, 2 reads both pointers
  // ------
  rsb_row_type rows [18] = '{
    '{8'hc0, 8'h55, 8'h00, 8'h0c, 8'h2a, 8'h8c, 8'h00, 3'h4, 2'h2, 2'h0},
    '{8'hc1, 8'h01, 8'h00, 8'h80, 8'h80, 8'hb0, 8'h00, 3'h4, 2'h2, 2'h0},
    '{8'hc0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h41, 8'h00, 3'h4, 2'h2, 2'h0},
    '{8'h4f, 8'h00, 8'h00, 8'hfd, 8'h00, 8'hfc, 8'h00, 3'h4, 2'h1, 2'h1},
    '{8'h5f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 3'h4, 2'h1, 2'h1},
    '{8'h32, 8'h10, 8'h03, 8'h80, 8'h0c, 8'h0c, 8'h00, 3'h4, 2'h2, 2'h0},
    '{8'h33, 8'h20, 8'h0a, 8'h80, 8'h15, 8'h0c, 8'h00, 3'h6, 2'h2, 2'h0},
    '{8'h34, 8'h20, 8'h8a, 8'h80, 8'h95, 8'hbc, 8'h00, 3'h6, 2'h3, 2'h0},
    '{8'h35, 8'h80, 8'h01, 8'h00, 8'h7f, 8'h1c, 8'h00, 3'h6, 2'h3, 2'h0},
    '{8'h36, 8'h05, 8'h05, 8'h01, 8'h00, 8'h49, 8'h00, 3'h6, 2'h3, 2'h0},
    '{8'h32, 8'h00, 8'hff, 8'h80, 8'h00, 8'hcc, 8'h00, 3'h4, 2'h2, 2'h0},
    '{8'hdf, 8'h00, 8'h00, 8'h7d, 8'h00, 8'hfd, 8'h00, 3'h4, 2'h1, 2'h1},
    '{8'hd0, 8'h9a, 8'h00, 8'h8c, 8'hcd, 8'h2c, 8'h00, 3'h4, 2'h2, 2'h0},
    '{8'hd1, 8'h01, 8'h00, 8'h10, 8'h00, 8'hc0, 8'h00, 3'h4, 2'h2, 2'h0},
    '{8'h31, 8'h40, 8'h40, 8'hfd, 8'h40, 8'hfd, 8'h48, 3'h4, 2'h2, 2'h2},
    '{8'h31, 8'h52, 8'h52, 8'h00, 8'h50, 8'h00, 8'h48, 3'h4, 2'h2, 2'h2},
    '{8'h31, 8'h69, 8'h69, 8'h00, 8'h50, 8'h00, 8'h68, 3'h4, 2'h2, 2'h2},
    '{8'h31, 8'h43, 8'h43, 8'h00, 8'h50, 8'h00, 8'h68, 3'h4, 2'h2, 2'h2}};
  logic [7:0] rst_idx [5] = '{IDX_WINDOW_POINTER_A, IDX_WINDOW_POINTER_B, IDX_FLAGS, IDX_RESULT, 8'h10};
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, busy_out;
  logic [7:0] flags_out, result_out;
  int err_total = 0;
  int checks = 0;
  always #10 core_clk = !core_clk;
  rsb_core rsb_core_i (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flags_out(flags_out),
    .result_out(result_out), .busy_out(busy_out));
  task automatic complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) err_total++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (busy_out !== 1'b0 && n < 40);
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] dst, input logic [7:0] src, input logic [7:0] fin);
    bus(1'b1, IDX_FLAGS, {24'h000000, fin});
    bus(1'b1, IDX_OPERAND, {16'h0000, src, dst});
    bus(1'b1, IDX_CONTROL, {24'h000000, op});
    idle();
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].dst, rows[i].src, rows[i].fin);
      cmp(flags_out, rows[i].fout);
      bus(1'b0, IDX_STATUS, 32'h00000000);
      cmp({q[6:4], q[2:0]}, {3'h1, rows[i].cyc});
      bus(1'b0, IDX_INFO, 32'h00000000);
      cmp(q[1:0], rows[i].byt);
      if (rows[i].kind == 2'h0) begin
        bus(1'b0, IDX_RESULT, 32'h00000000);
        cmp(q[7:0], rows[i].res);
      end else if (rows[i].kind == 2'h2) begin
        bus(1'b0, IDX_WINDOW_POINTER_A, 32'h00000000);
        cmp(q[7:0], rows[i].res);
        bus(1'b0, IDX_WINDOW_POINTER_B, 32'h00000000);
        cmp(q[7:0], rows[i].pb);
      end
    end
    // A flags write landing mid-instruction must not leak into the commit.
    bus(1'b1, IDX_FLAGS, 32'h00000000);
    bus(1'b1, IDX_CONTROL, {24'h000000, OPC_SETC});
    bus(1'b1, IDX_FLAGS, 32'h0000007c);
    idle();
    bus(1'b0, IDX_FLAGS, 32'h00000000);
    cmp(q[7:0], 8'h80);
    run(8'h00, 8'h00, 8'h00, 8'h85);
    bus(1'b0, IDX_STATUS, 32'h00000000);
    cmp({q[5], flags_out}, {1'b1, 8'h85});
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(1'b1, 8'h10, 32'h000000ff);
    // A flags write with lane 0 disabled must leave the flags at their reset value.
    avs_byteenable <= 4'h2;
    bus(1'b1, IDX_FLAGS, 32'h000000ff);
    avs_byteenable <= 4'hf;
    foreach (rst_idx[i]) begin
      bus(1'b0, rst_idx[i], 32'h00000000);
      cmp(q, {24'h000000, RST_BYTE});
    end
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
